// *** hdl/mtp_pkg.sv ***
// Package for the motor temperature protection block: map, fields, constants
package mtp_pkg;

    // ****************************************************
    // Register map (byte addresses, one word each)
    // ****************************************************
    localparam logic [11:0] ADDR_SENSOR_TYPE = 12'h000;
    localparam logic [11:0] ADDR_CONTROL     = 12'h004;
    localparam logic [11:0] ADDR_PT_WARN     = 12'h008;
    localparam logic [11:0] ADDR_PT_FAULT    = 12'h00c;
    localparam logic [11:0] ADDR_AN_WARN     = 12'h010;
    localparam logic [11:0] ADDR_AN_FAULT    = 12'h014;
    localparam logic [11:0] ADDR_STATUS      = 12'h018;
    localparam logic [11:0] ADDR_FAULT_COUNT = 12'h01c;
    localparam logic [11:0] ADDR_TEMP        = 12'h020;
    localparam logic [11:0] ADDR_COMMAND     = 12'h024;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int CTL_FAULT_EN_BIT = 0;
    localparam int CTL_WARN_EN_BIT  = 1;
    localparam int CTL_UNIT_BIT     = 2;
    localparam int CMD_START_BIT    = 0;
    localparam int CMD_STOP_BIT     = 1;
    localparam int CMD_RESET_BIT    = 2;
    localparam int STS_WARN_BIT     = 0;
    localparam int STS_FAULT_BIT    = 1;
    localparam int STS_RUN_BIT      = 2;
    localparam int STS_LATCH_BIT    = 3;

    // ****************************************************
    // Factory values and fixed thresholds
    // ****************************************************
    localparam logic [7:0]  PT_THR_RESET   = 8'h00;   // 0 degC
    localparam logic [7:0]  PT_THR_MAX     = 8'hc8;   // 200 degC
    localparam logic [15:0] AN_THR_RESET   = 16'h00c8; // 20.0 ohm, tenths
    localparam logic [15:0] BIN_TRIP_DOHM  = 16'h7148; // 2900.0 ohm
    localparam logic [15:0] BIN_CLOSE_DOHM = 16'h3d86; // 1575.0 ohm
    // Gain 2.6042 and offset 260.42 in 1/10000 units
    localparam int PT_GAIN_E4    = 26042;
    localparam int PT_OFFSET_E4  = 2604200;
    localparam int HYST_PCT      = 95;

    // ****************************************************
    // Detection time
    // ****************************************************
    localparam int CLK_HZ       = 100000000;
    localparam int DETECT_MS    = 500;
    localparam int DETECT_CYC   = DETECT_MS * (CLK_HZ / 1000);

    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [1:0]
    {
        SENS_NONE   = 2'b00,
        SENS_BINARY = 2'b01,
        SENS_PLAT   = 2'b10,
        SENS_ANALOG = 2'b11
    } mtp_sensor_t;

    typedef enum logic [1:0]
    {
        RUN_STOPPED = 2'b00,
        RUN_RUNNING = 2'b01,
        RUN_LOCKED  = 2'b10
    } mtp_run_t;

    typedef struct packed
    {
        logic        warn;
        logic        fault;
        logic        running;
    } mtp_out_t;

endpackage

// *** hdl/mtp_protect.sv ***
// Motor winding temperature protection with APB register access
// ****************************************************
// Notes on behaviour
// - One sensor type active; factory none
// - Changing type restores factory settings
// - Same type rewrite keeps settings
// - Binary: trip above 2900 ohm
// - Binary: hold until below 1575 ohm
// - Binary thresholds fixed; fault enable gates
// - Warning and fault enables independent
// - Protection active in all run states
// - Declare only after 0.5 s persistence
// - Count each newly declared fault
// - Fresh start needed after fault reset
// - Platinum: warn and fault thresholds separate
// - Platinum thresholds 0 to 200 degC
// - Platinum: release below 95 percent
// - Platinum temperature equals gain*R minus offset
// - Unit bit: 0 Celsius, 1 Fahrenheit
// - Analog: warning above warn threshold
// - Analog: fault above own threshold
// - Analog: release below 95 percent
// ****************************************************
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

module mtp_protect
    import mtp_pkg::*;
#(
    parameter int DETECT_CYCLES = DETECT_CYC,
    parameter int COUNT_W       = 16
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Measured sensor resistance, tenths of an ohm
    input  wire logic [15:0] sensorOhmDeci,
    // Protection outputs
    output mtp_out_t         protOut
);

    // ****************************************************
    // Registers
    // ****************************************************
    // Configuration held for software
    mtp_sensor_t           sensorType_r;
    logic                  faultEn_r;
    logic                  warnEn_r;
    logic                  unitSel_r;
    logic [7:0]            ptWarn_r;
    logic [7:0]            ptFault_r;
    logic [15:0]           anWarn_r;
    logic [15:0]           anFault_r;
    logic [COUNT_W-1:0]    faultCount_r;
    // Detection and run state
    logic                  warnOut_r;
    logic                  faultOut_r;
    logic [31:0]           warnTimer_r;
    logic [31:0]           faultTimer_r;
    mtp_run_t              runState_r;
    logic signed [15:0]    tempOut_r;
    logic [31:0]           prdata_r;

    // Bus strobes and compare results
    logic                  wrEn;
    logic                  rdEn;
    logic                  addrOk;
    logic signed [31:0]    tempC;
    logic signed [63:0]    ptScaled;
    logic signed [31:0]    tempF;
    logic                  warnAbove;
    logic                  warnBelow;
    logic                  faultAbove;
    logic                  faultBelow;
    logic                  warnPending;
    logic                  faultPending;
    logic                  faultRise;
    logic                  cmdStart;
    logic                  cmdStop;
    logic                  cmdReset;

    // Single-cycle access: the slave answers in the first access cycle
    assign wrEn    = psel && penable && pwrite;
    // Read data is fetched in the setup cycle so it stands through access
    assign rdEn    = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addrOk;
    assign prdata  = prdata_r;

    // Only the ten word addresses decode; the rest answer with an error
    always_comb
    begin
        case (paddr)
            ADDR_SENSOR_TYPE, ADDR_CONTROL, ADDR_PT_WARN, ADDR_PT_FAULT,
            ADDR_AN_WARN, ADDR_AN_FAULT, ADDR_STATUS, ADDR_FAULT_COUNT,
            ADDR_TEMP, ADDR_COMMAND: addrOk = 1'b1;
            default:                 addrOk = 1'b0;
        endcase
    end

    // Start, stop and reset commands are write pulses
    assign cmdStart = wrEn && (paddr == ADDR_COMMAND) && pwdata[CMD_START_BIT];
    assign cmdStop  = wrEn && (paddr == ADDR_COMMAND) && pwdata[CMD_STOP_BIT];
    assign cmdReset = wrEn && (paddr == ADDR_COMMAND) && pwdata[CMD_RESET_BIT];

    // ****************************************************
    // Configuration
    // ****************************************************
    // Type change restores factory values; same-type rewrite leaves them
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sensorType_r <= SENS_NONE;
            faultEn_r    <= 1'b0;
            warnEn_r     <= 1'b0;
            unitSel_r    <= 1'b0;
            ptWarn_r     <= PT_THR_RESET;
            ptFault_r    <= PT_THR_RESET;
            anWarn_r     <= AN_THR_RESET;
            anFault_r    <= AN_THR_RESET;
        end
        else if (wrEn && paddr == ADDR_SENSOR_TYPE)
        begin
            sensorType_r <= mtp_sensor_t'(pwdata[1:0]);
            // Old settings never meet the compares of a new type
            if (mtp_sensor_t'(pwdata[1:0]) != sensorType_r)
            begin
                faultEn_r <= 1'b0;
                warnEn_r  <= 1'b0;
                unitSel_r <= 1'b0;
                ptWarn_r  <= PT_THR_RESET;
                ptFault_r <= PT_THR_RESET;
                anWarn_r  <= AN_THR_RESET;
                anFault_r <= AN_THR_RESET;
            end
        end
        else if (wrEn)
        begin
            case (paddr)
                ADDR_CONTROL:
                begin
                    faultEn_r <= pwdata[CTL_FAULT_EN_BIT];
                    warnEn_r  <= pwdata[CTL_WARN_EN_BIT];
                    unitSel_r <= pwdata[CTL_UNIT_BIT];
                end
                // Out-of-range values saturate at the top of the range
                ADDR_PT_WARN:
                    ptWarn_r  <= (pwdata[31:0] > 32'(PT_THR_MAX)) ? PT_THR_MAX : pwdata[7:0];
                ADDR_PT_FAULT:
                    ptFault_r <= (pwdata[31:0] > 32'(PT_THR_MAX)) ? PT_THR_MAX : pwdata[7:0];
                // Analog thresholds are taken as written, in tenths
                ADDR_AN_WARN:  anWarn_r  <= pwdata[15:0];
                ADDR_AN_FAULT: anFault_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ****************************************************
    // Temperature and threshold compare
    // ****************************************************
    // Resistance is in tenths, so the gain term carries an extra factor of ten
    assign ptScaled = ($signed(64'(sensorOhmDeci)) * PT_GAIN_E4) / 10 - PT_OFFSET_E4;
    // Signed all the way: a cold probe reads below zero instead of wrapping
    assign tempC    = 32'(ptScaled / 10000);
    assign tempF = 32'((tempC * 9) / 5 + 32);

    // Compare sets per mode; hysteresis as x*100 vs thr*95 avoids a divider
    always_comb
    begin
        // Idle defaults: nothing above, everything released
        warnAbove  = 1'b0;
        warnBelow  = 1'b1;
        faultAbove = 1'b0;
        faultBelow = 1'b1;
        case (sensorType_r)
            SENS_BINARY:
            begin
                warnAbove  = sensorOhmDeci > BIN_TRIP_DOHM;
                faultAbove = warnAbove;
                warnBelow  = sensorOhmDeci < BIN_CLOSE_DOHM;
                faultBelow = warnBelow;
            end
            SENS_PLAT:
            begin
                // Signed compare so negative readings stay below any threshold
                warnAbove  = tempC > $signed(32'(ptWarn_r));
                faultAbove = tempC > $signed(32'(ptFault_r));
                warnBelow  = tempC * 100 < $signed(32'(ptWarn_r)) * HYST_PCT;
                faultBelow = tempC * 100 < $signed(32'(ptFault_r)) * HYST_PCT;
            end
            SENS_ANALOG:
            begin
                // Widened so the percentage products cannot overflow
                warnAbove  = sensorOhmDeci > anWarn_r;
                faultAbove = sensorOhmDeci > anFault_r;
                warnBelow  = 32'(sensorOhmDeci) * 100 < 32'(anWarn_r) * HYST_PCT;
                faultBelow = 32'(sensorOhmDeci) * 100 < 32'(anFault_r) * HYST_PCT;
            end
            default: ;
        endcase
    end

    // A disabled function never starts its detection timer
    assign warnPending  = warnEn_r && (sensorType_r != SENS_NONE) && warnAbove;
    assign faultPending = faultEn_r && (sensorType_r != SENS_NONE) && faultAbove;

    // ****************************************************
    // Detection timers and outputs
    // ****************************************************
    // Timers run regardless of run state; a dip below trip restarts them
    always_ff @(posedge mclk)
    begin
        if (rst || !warnPending)
            warnTimer_r <= 32'h0;
        else if (warnTimer_r < 32'(DETECT_CYCLES))
            warnTimer_r <= warnTimer_r + 32'h1;
    end

    // Fault timer, independent of the warning timer
    always_ff @(posedge mclk)
    begin
        if (rst || !faultPending)
            faultTimer_r <= 32'h0;
        else if (faultTimer_r < 32'(DETECT_CYCLES))
            faultTimer_r <= faultTimer_r + 32'h1;
    end

    // Warning output; a new trip wins over a release in the same cycle
    always_ff @(posedge mclk)
    begin
        if (rst || !warnEn_r || sensorType_r == SENS_NONE)
            warnOut_r <= 1'b0;
        else if (warnTimer_r == 32'(DETECT_CYCLES) - 32'h1)
            warnOut_r <= 1'b1;
        else if (warnBelow)
            warnOut_r <= 1'b0;
    end

    // One pulse per newly declared fault, shared by output and counter
    assign faultRise = faultPending && !faultOut_r && (faultTimer_r == 32'(DETECT_CYCLES) - 32'h1);

    // Fault output; held until released or disabled
    always_ff @(posedge mclk)
    begin
        if (rst || !faultEn_r || sensorType_r == SENS_NONE)
            faultOut_r <= 1'b0;
        else if (faultRise)
            faultOut_r <= 1'b1;
        else if (faultBelow)
            faultOut_r <= 1'b0;
    end

    // Counter saturates rather than wrapping back to zero
    always_ff @(posedge mclk)
    begin
        if (rst)
            faultCount_r <= '0;
        else if (faultRise && faultCount_r != '1)
            faultCount_r <= faultCount_r + 1'b1;
    end

    // ****************************************************
    // Run state
    // ****************************************************
    // A fault forces a lock; reset only returns to stopped, never to run
    always_ff @(posedge mclk)
    begin
        if (rst)
            runState_r <= RUN_STOPPED;
        else
        begin
            // Stop is ignored while locked; only reset leaves the lock
            case (runState_r)
                RUN_STOPPED:
                    if (faultOut_r)
                        runState_r <= RUN_LOCKED;
                    else if (cmdStart)
                        runState_r <= RUN_RUNNING;
                RUN_RUNNING:
                    if (faultOut_r)
                        runState_r <= RUN_LOCKED;
                    else if (cmdStop)
                        runState_r <= RUN_STOPPED;
                RUN_LOCKED:
                    if (!faultOut_r && cmdReset)
                        runState_r <= RUN_STOPPED;
                default:
                    runState_r <= RUN_STOPPED;
            endcase
        end
    end

    // Output bundle for the motor control side
    assign protOut.warn    = warnOut_r;
    assign protOut.fault   = faultOut_r;
    assign protOut.running = (runState_r == RUN_RUNNING);

    // ****************************************************
    // Read path
    // ****************************************************
    // Reported temperature in the selected unit
    always_ff @(posedge mclk)
    begin
        if (rst)
            tempOut_r <= 16'sh0;
        else
            tempOut_r <= unitSel_r ? 16'(tempF) : 16'(tempC);
    end

    // Read mux; status reflects the cycle before the access phase
    always_ff @(posedge mclk)
    begin
        if (rst)
            prdata_r <= 32'h0;
        else if (rdEn)
        begin
            case (paddr)
                ADDR_SENSOR_TYPE: prdata_r <= {30'h0, sensorType_r};
                ADDR_CONTROL:     prdata_r <= {29'h0, unitSel_r, warnEn_r, faultEn_r};
                ADDR_PT_WARN:     prdata_r <= {24'h0, ptWarn_r};
                ADDR_PT_FAULT:    prdata_r <= {24'h0, ptFault_r};
                ADDR_AN_WARN:     prdata_r <= {16'h0, anWarn_r};
                ADDR_AN_FAULT:    prdata_r <= {16'h0, anFault_r};
                ADDR_STATUS:      prdata_r <= {28'h0, runState_r == RUN_LOCKED,
                                               runState_r == RUN_RUNNING, faultOut_r, warnOut_r};
                ADDR_FAULT_COUNT: prdata_r <= 32'(faultCount_r);
                ADDR_TEMP:        prdata_r <= {{16{tempOut_r[15]}}, tempOut_r};
                default:          prdata_r <= 32'h0;
            endcase
        end
    end

endmodule

// *** tb/mtp_sensor_model.sv ***
// Model of the sensing element resistance seen by the block
`timescale 1ns/1ps
module mtp_sensor_model
(
    // Clock
    input  wire logic        mclk,
    // Resistance asked for by the bench, tenths of an ohm
    input  wire logic [15:0] ohmSet,
    // Resistance across the sensor terminals
    output logic      [15:0] sensorOhmDeci
);
    // Element lags one cycle; a real winding drifts far slower
    always_ff @(posedge mclk)
    begin
        sensorOhmDeci <= ohmSet;
    end
endmodule

// *** tb/mtp_protect_assertions.sv ***
// Concurrent checks on the ports of the protection block
`timescale 1ns/1ps
module mtp_protect_assertions
    import mtp_pkg::*;
#(
    parameter int DETECT_CYCLES = DETECT_CYC
)
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sensor and outputs
    input wire logic [15:0] sensorOhmDeci,
    input wire mtp_out_t    protOut
);
    int upCnt;

    // Cycles since reset; no trip may come sooner than the detection time
    always_ff @(posedge mclk)
    begin
        if (rst)
            upCnt <= 0;
        else if (upCnt < DETECT_CYCLES)
            upCnt <= upCnt + 1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************************************************
    // Assertions
    // ****************************************************
    reset_outputs_a: assert property (disable iff (1'b0) rst |=> protOut == 3'b000 && prdata == 32'h0)
        else $error("outputs not cleared by reset");
    ready_high_a: assert property (pready)
        else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    err_unmapped_a: assert property (psel && penable && paddr > ADDR_COMMAND |-> pslverr)
        else $error("unmapped access not refused");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    detect_delay_a: assert property ($rose(protOut.warn) || $rose(protOut.fault) |-> upCnt >= DETECT_CYCLES - 1)
        else $error("trip sooner than detection time");
    lock_fault_a: assert property ($rose(protOut.fault) |-> ##[1:2] !protOut.running)
        else $error("still running after fault");
    start_cmd_a: assert property ($rose(protOut.running) |->
        $past(psel && penable && pwrite && paddr == ADDR_COMMAND && pwdata[CMD_START_BIT]))
        else $error("run without start command");

    // Main scenarios reached
    cover property ($rose(protOut.fault));
    cover property ($rose(protOut.warn));
    cover property ($rose(protOut.running));
    cover property (pslverr);
endmodule

bind mtp_protect mtp_protect_assertions #(.DETECT_CYCLES(DETECT_CYCLES)) mtp_protect_assertions_i
(
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensorOhmDeci(sensorOhmDeci), .protOut(protOut)
);

// *** tb/motor_temp_sensor_protection_tb.sv ***
// Self-checking bench for the motor temperature protection block
`timescale 1ns/1ps
module motor_temp_sensor_protection_tb
    import mtp_pkg::*;
;
    localparam int DT = 20;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        errSeen;
    logic [15:0] ohmSet = 16'h0000;
    logic [15:0] sensorOhmDeci;
    logic [31:0] rdVal;
    logic [31:0] cnt0;
    mtp_out_t    protOut;
    int          bad_count = 0;
    int          tests_run = 0;
    logic [11:0] rstA [8] = '{ADDR_SENSOR_TYPE, ADDR_CONTROL, ADDR_PT_WARN, ADDR_PT_FAULT,
                              ADDR_AN_WARN, ADDR_AN_FAULT, ADDR_STATUS, ADDR_FAULT_COUNT};
    logic [31:0] rstV [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hc8, 32'hc8, 32'h0, 32'h0};

    // 100 MHz clock
    always #5 mclk = ~mclk;

    mtp_protect #(.DETECT_CYCLES(DT)) mtp_protect_i (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sensorOhmDeci(sensorOhmDeci), .protOut(protOut));
    mtp_sensor_model mtp_sensor_model_i (.mclk(mclk), .ohmSet(ohmSet), .sensorOhmDeci(sensorOhmDeci));

    // ****************************************************
    // Tasks
    // ****************************************************
    // One APB transfer; an idle edge follows so psel is never driven twice at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // No limit of its own: only the watchdog ends a stuck wait
        while (pready !== 1'b1)
            @(posedge mclk);
        rdVal = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("register %h", a), e, rdVal);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog sized well above the whole sequence
    initial
    begin
        wt(5000);
        bad_count++;
        $display("unexpected timeout: expected end seen hang");
        tally_and_finish;
    end

    // ****************************************************
    // Tests
    // ****************************************************
    initial
    begin
        wt(8);
        rst <= 1'b0;
        @(posedge mclk);
        foreach (rstA[i]) rc(rstA[i], rstV[i]);
        apb(1'b0, 12'h030, 32'h0);
        cmp("slverr", 32'h1, {31'h0, errSeen});
        cmp("unmapped read", 32'h0, rdVal);
        $display("test reset and map done");
        wr(ADDR_SENSOR_TYPE, 32'h1);
        wr(ADDR_CONTROL, 32'h3);
        ohmSet <= 16'd29000;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h0);
        ohmSet <= 16'd29010;
        wt(DT - 4);
        ohmSet <= 16'd20000;
        wt(2);
        ohmSet <= 16'd29010;
        wt(DT - 4);
        rc(ADDR_STATUS, 32'h0);
        wt(6);
        rc(ADDR_STATUS, 32'h0b);
        cmp("protOut", 32'h6, {29'h0, protOut});
        rc(ADDR_FAULT_COUNT, 32'h1);
        ohmSet <= 16'd15750;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h0b);
        ohmSet <= 16'd15749;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h08);
        $display("test binary done");
        wr(ADDR_COMMAND, 32'h1);
        rc(ADDR_STATUS, 32'h08);
        wr(ADDR_COMMAND, 32'h4);
        rc(ADDR_STATUS, 32'h0);
        wr(ADDR_COMMAND, 32'h1);
        rc(ADDR_STATUS, 32'h04);
        wr(ADDR_COMMAND, 32'h2);
        rc(ADDR_STATUS, 32'h0);
        wr(ADDR_COMMAND, 32'h1);
        cmp("protOut", 32'h1, {29'h0, protOut});
        wr(ADDR_SENSOR_TYPE, 32'h1);
        rc(ADDR_CONTROL, 32'h3);
        wr(ADDR_SENSOR_TYPE, 32'h3);
        rc(ADDR_CONTROL, 32'h0);
        rc(ADDR_AN_WARN, 32'hc8);
        $display("test restart and type change done");
        wr(ADDR_AN_WARN, 32'd1000);
        wr(ADDR_AN_FAULT, 32'd2000);
        wr(ADDR_CONTROL, 32'h2);
        ohmSet <= 16'd2100;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h05);
        cmp("protOut", 32'h5, {29'h0, protOut});
        ohmSet <= 16'd950;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h05);
        ohmSet <= 16'd949;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h04);
        apb(1'b0, ADDR_FAULT_COUNT, 32'h0);
        cnt0 = rdVal;
        wr(ADDR_CONTROL, 32'h3);
        ohmSet <= 16'd2100;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h0b);
        rc(ADDR_FAULT_COUNT, cnt0 + 32'h1);
        wr(ADDR_CONTROL, 32'h2);
        rc(ADDR_STATUS, 32'h09);
        $display("test analog done");
        wr(ADDR_COMMAND, 32'h4);
        wr(ADDR_SENSOR_TYPE, 32'h2);
        wr(ADDR_CONTROL, 32'h3);
        wr(ADDR_PT_WARN, 32'd100);
        wr(ADDR_PT_FAULT, 32'd250);
        rc(ADDR_PT_FAULT, 32'd200);
        ohmSet <= 16'd1500;
        wt(DT + 5);
        rc(ADDR_TEMP, 32'd130);
        rc(ADDR_STATUS, 32'h01);
        wr(ADDR_CONTROL, 32'h7);
        rc(ADDR_TEMP, 32'd266);
        wr(ADDR_CONTROL, 32'h3);
        ohmSet <= 16'd1369;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h01);
        ohmSet <= 16'd1363;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h0);
        wr(ADDR_SENSOR_TYPE, 32'h0);
        ohmSet <= 16'hea60;
        wt(DT + 5);
        rc(ADDR_STATUS, 32'h0);
        $display("test platinum and none done");
        tally_and_finish;
    end
endmodule
